// File: verilog/tphf_pkg.sv
// Package for the tunnel packet header framer: field codes, layout, register map.
// Assumes a single 200 MHz clock domain and a byte-wide header output stream.
package tphf_pkg;
   localparam logic [1:0]  TPHF_RTP_VERSION      = 2'h2;
   localparam logic [3:0]  TPHF_CONTRIBUTOR_CNT  = 4'h0;
   localparam logic [1:0]  TPHF_TUNNEL_REVISION  = 2'h1;
   localparam logic [6:0]  TPHF_PT_DATA_SOURCE   = 7'h51;
   localparam logic [6:0]  TPHF_PT_LINK_LAYER    = 7'h52;
   localparam logic [6:0]  TPHF_PT_XMIT_LINK     = 7'h61;
   localparam int          TPHF_HDR_BYTES        = 16;
   localparam logic [3:0]  TPHF_LAST_BYTE        = 4'hf;
   // Register offsets on the plain register port (word index)
   localparam logic [3:0]  TPHF_REG_CTRL         = 4'h0;
   localparam logic [3:0]  TPHF_REG_SEQ          = 4'h1;
   localparam logic [3:0]  TPHF_REG_XLINK_TIME   = 4'h2;
   localparam logic [3:0]  TPHF_REG_STATUS       = 4'h3;
   localparam logic [3:0]  TPHF_REG_EXT_LEN      = 4'h4;
   localparam logic [3:0]  TPHF_REG_COUNT        = 4'h5;
   // Reset values
   localparam logic [15:0] TPHF_SEQ_RESET        = 16'h0000;
   localparam logic [6:0]  TPHF_PT_RESET         = 7'h51;

   // Request from the packer: what this tunnel packet holds
   typedef struct packed {
      logic        start_present;   // An inner packet begins in this payload
      logic [15:0] start_offset;    // Bytes from header end to that start
      logic        info_present;    // Any inner information header present
      logic [31:0] earliest_time;   // Seconds[15:0] then fraction[15:0]
      logic        padding;
      logic        extension;
      logic [15:0] ext_len;         // Extension length in 32-bit words
      logic        is_control;      // Control-report packet, never framed
   } tphf_req_t;

   typedef enum logic [1:0] {
      TPHF_IDLE = 2'b00,
      TPHF_EMIT = 2'b01,
      TPHF_DONE = 2'b11
   } tphf_state_t;
endpackage

// File: verilog/tphf_framer.sv
// Tunnel packet header framer: builds the 16-byte fixed header and emits it bytewise.
// Assumes the packer sends payloads of one fixed size and the UDP/IPv4 multicast
// wrapper sits downstream; control bits come over a plain register port.
`timescale 1ns/1ps
module tphf_framer
   import tphf_pkg::*;
#(
   parameter int SEQ_W = 16
) (
   input  wire logic        clk,
   input  wire logic        rst,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // Request from the packer
   input  wire logic        req_valid,
   input  tphf_req_t        req,
   output logic             req_ready,
   // Byte stream of the header, MSB of each field first
   output logic             hdr_valid,
   output logic [7:0]       hdr_byte,
   output logic             hdr_last,
   input  wire logic        hdr_ready,
   // Sideband for the multicast wrapper
   output logic             pkt_done,
   output logic             pkt_dropped
);

   // Elaboration check: the sequence counter and read-back assume 16 bits
   if (SEQ_W != 16) begin : gen_seq_w_check
      $error("tphf_framer: sequence number must be 16 bits");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   logic [6:0]       pt_reg;
   logic [1:0]       chan_reg;
   logic [SEQ_W-1:0] seq_reg;
   logic [31:0]      xlink_time_reg;
   logic [15:0]      ext_len_reg;
   logic             ext_lock_reg;
   logic             ext_err_reg;
   logic             ctrl_drop_reg;
   logic [15:0]      count_reg;
   logic [127:0]     hdr_reg;
   logic [3:0]       idx_reg;
   tphf_state_t      state_reg;
   logic             busy;

   assign busy = (state_reg != TPHF_IDLE);
   // Handshake output is combinational; only idle framer takes a request
   assign req_ready = !busy;

   wire take = req_valid && req_ready;
   wire send = hdr_valid && hdr_ready;
   wire last = send && (idx_reg == TPHF_LAST_BYTE);

   // Mode control; retuning the type mid-packet would split a stream, so only idle
   always_ff @(posedge clk) begin
      if (rst) begin
         pt_reg   <= TPHF_PT_RESET;
         chan_reg <= 2'h0;
      end else if (reg_wr && reg_addr == TPHF_REG_CTRL && !busy) begin
         pt_reg   <= reg_wdata[6:0];
         chan_reg <= reg_wdata[9:8];
      end
   end

   // Sequence counter: software seeds it, each sent header advances it
   always_ff @(posedge clk) begin
      if (rst) begin
         seq_reg <= TPHF_SEQ_RESET;
      end else if (last) begin
         seq_reg <= seq_reg + 16'h0001;                // wraps at 65536
      end else if (reg_wr && reg_addr == TPHF_REG_SEQ && !busy) begin
         seq_reg <= reg_wdata[15:0];
      end
   end

   // Latest-delivery time used for transmitter-link packets
   always_ff @(posedge clk) begin
      if (rst) begin
         xlink_time_reg <= 32'h0000_0000;              // zero is best effort
      end else if (reg_wr && reg_addr == TPHF_REG_XLINK_TIME) begin
         xlink_time_reg <= reg_wdata;
      end
   end

   // Extension length locks on first extended packet; later mismatches flag an error
   always_ff @(posedge clk) begin
      if (rst) begin
         ext_len_reg  <= 16'h0000;
         ext_lock_reg <= 1'b0;
         ext_err_reg  <= 1'b0;
      end else begin
         if (take && req.extension && !req.is_control && !ext_lock_reg) begin
            ext_len_reg  <= req.ext_len;
            ext_lock_reg <= 1'b1;
         end
         // Set wins over a same-cycle clear
         if (take && !req.is_control && ext_lock_reg &&
             (!req.extension || req.ext_len != ext_len_reg)) begin
            ext_err_reg <= 1'b1;
         end else if (reg_wr && reg_addr == TPHF_REG_STATUS && reg_wdata[0]) begin
            ext_err_reg <= 1'b0;
         end
      end
   end

   // Sticky flag for refused control packets; set wins over clear
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_drop_reg <= 1'b0;
      end else if (take && req.is_control) begin
         ctrl_drop_reg <= 1'b1;
      end else if (reg_wr && reg_addr == TPHF_REG_STATUS && reg_wdata[1]) begin
         ctrl_drop_reg <= 1'b0;
      end
   end

   // Count of headers sent, for software sanity checks
   always_ff @(posedge clk) begin
      if (rst) begin
         count_reg <= 16'h0000;
      end else if (last) begin
         count_reg <= count_reg + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Header assembly

   logic [31:0] time_word;
   logic [15:0] mode_bits;
   logic [15:0] offset_word;

   // Time word depends on payload type
   always_comb begin
      if (pt_reg == TPHF_PT_DATA_SOURCE || pt_reg == TPHF_PT_LINK_LAYER) begin
         // Seconds low half then fraction half
         time_word = req.info_present ? req.earliest_time : 32'h0000_0000;
      end else if (pt_reg == TPHF_PT_XMIT_LINK) begin
         time_word = xlink_time_reg;
      end else begin
         time_word = 32'h0000_0000;
      end
   end

   // Revision plus type-dependent tail bits
   always_comb begin
      if (pt_reg == TPHF_PT_XMIT_LINK) begin
         // Two zero bits, duplication bits from chan_reg, then ten zero bits
         mode_bits = {TPHF_TUNNEL_REVISION, 2'h0, chan_reg, 10'h000};
      end else begin
         mode_bits = {TPHF_TUNNEL_REVISION, 14'h0000};
      end
   end

   // Offset only meaningful with marker; zero otherwise keeps the field clean
   assign offset_word = req.start_present ? req.start_offset : 16'h0000;

   // Capture the whole header at request time so later input changes cannot tear it
   always_ff @(posedge clk) begin
      if (rst) begin
         hdr_reg <= 128'h0;
      end else if (take && !req.is_control) begin
         hdr_reg <= {TPHF_RTP_VERSION,
                     req.padding,
                     req.extension,
                     TPHF_CONTRIBUTOR_CNT,
                     req.start_present,
                     pt_reg,
                     seq_reg,
                     time_word,
                     mode_bits,
                     offset_word,
                     32'h0000_0000};                   // Fields fill 12 bytes; last 4 go out as zero
      end else if (send) begin
         hdr_reg <= {hdr_reg[119:0], 8'h00};           // MSB byte first
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Emission state machine

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= TPHF_IDLE;
      end else begin
         case (state_reg)
            TPHF_IDLE: begin
               if (take && !req.is_control) begin
                  state_reg <= TPHF_EMIT;
               end
            end
            TPHF_EMIT: begin
               if (last) begin
                  state_reg <= TPHF_DONE;
               end
            end
            TPHF_DONE: begin
               state_reg <= TPHF_IDLE;
            end
            default: begin
               state_reg <= TPHF_IDLE;
            end
         endcase
      end
   end

   // Byte index within the 16-byte header
   always_ff @(posedge clk) begin
      if (rst) begin
         idx_reg <= 4'h0;
      end else if (take) begin
         idx_reg <= 4'h0;
      end else if (send) begin
         idx_reg <= idx_reg + 4'h1;
      end
   end

   // Completion and drop pulses for the multicast wrapper
   always_ff @(posedge clk) begin
      if (rst) begin
         pkt_done    <= 1'b0;
         pkt_dropped <= 1'b0;
      end else begin
         pkt_done    <= last;                          // wrapper adds UDP/IPv4
         pkt_dropped <= take && req.is_control;
      end
   end

   assign hdr_valid = (state_reg == TPHF_EMIT);
   assign hdr_byte  = hdr_reg[127:120];
   assign hdr_last  = hdr_valid && (idx_reg == TPHF_LAST_BYTE);

   ////////////////////////////////////////////////////////////////////////////
   // Register read port, data one cycle after the strobe

   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            TPHF_REG_CTRL:       reg_rdata <= {22'h0, chan_reg, 1'b0, pt_reg};
            TPHF_REG_SEQ:        reg_rdata <= {16'h0, seq_reg};
            TPHF_REG_XLINK_TIME: reg_rdata <= xlink_time_reg;
            TPHF_REG_STATUS:     reg_rdata <= {28'h0, busy, ext_lock_reg, ctrl_drop_reg, ext_err_reg};
            TPHF_REG_EXT_LEN:    reg_rdata <= {16'h0, ext_len_reg};
            TPHF_REG_COUNT:      reg_rdata <= {16'h0, count_reg};
            default:             reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

endmodule

// File: verification/tphf_framer_properties.sv
// Checker for the header framer: byte layout and handshake timing.
// Assumes it is bound to tphf_framer and sees only its ports.
`timescale 1ns/1ps
module tphf_framer_chk
   import tphf_pkg::*;
#(
   parameter int SEQ_W = 16
) (
   input logic        clk,
   input logic        rst,
   input logic [3:0]  reg_addr,
   input logic [31:0] reg_wdata,
   input logic        reg_wr,
   input logic        reg_rd,
   input logic [31:0] reg_rdata,
   input logic        req_valid,
   input tphf_req_t   req,
   input logic        req_ready,
   input logic        hdr_valid,
   input logic [7:0]  hdr_byte,
   input logic        hdr_last,
   input logic        hdr_ready,
   input logic        pkt_done,
   input logic        pkt_dropped
);
   logic [4:0] cnt;
   tphf_req_t  cap;
   logic [6:0] pt_q;
   logic       take;
   logic       acc;
   logic       dt;
   ////////////////////////////////////////
   // Byte index restarts at every take so a stray byte shows up as a shift
   assign take = req_valid && req_ready;
   assign acc  = hdr_valid && hdr_ready;
   assign dt   = pt_q == 7'h51 || pt_q == 7'h52;
   always_ff @(posedge clk) begin
      if (rst || take) cnt <= 5'h0;
      else if (acc) cnt <= cnt + 5'h1;
   end
   // Request held for the whole header; type taken from byte 1 and held for the rest
   always_ff @(posedge clk) begin
      if (take) cap <= req;
      if (acc && cnt == 5'h1) pt_q <= hdr_byte[6:0];
   end
   ////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ver_byte_a: assert property (hdr_valid && cnt == 5'h0 |-> hdr_byte[7:6] == 2'h2 && hdr_byte[3:0] == 4'h0)
      else $error("bad first header byte");
   flag_copy_a: assert property (take && !req.is_control |=> hdr_byte[5:4] == {$past(req.padding), $past(req.extension)})
      else $error("flags not copied");
   marker_bit_a: assert property (hdr_valid && cnt == 5'h1 |-> hdr_byte[7] == cap.start_present)
      else $error("marker wrong");
   offset_hi_a: assert property (hdr_valid && cnt == 5'ha |-> hdr_byte == (cap.start_present ? cap.start_offset[15:8] : 8'h0))
      else $error("offset wrong");
   time_word_a: assert property (hdr_valid && cnt >= 5'h4 && cnt <= 5'h7 && pt_q != 7'h61
      |-> hdr_byte == (dt && cap.info_present ? cap.earliest_time[8*(7-cnt)+:8] : 8'h0))
      else $error("time word wrong");
   rev_field_a: assert property (hdr_valid && cnt == 5'h8 |-> hdr_byte[7:4] == 4'h4 && hdr_byte[1:0] == 2'h0 && (pt_q == 7'h61 || hdr_byte[3:2] == 2'h0))
      else $error("revision byte wrong");
   tail_zero_a: assert property (hdr_valid && cnt == 5'h9 |-> hdr_byte == 8'h0)
      else $error("reserved bits set");
   byte_hold_a: assert property (hdr_valid && !hdr_ready |=> hdr_valid && $stable(hdr_byte))
      else $error("byte dropped under stall");
   last_flag_a: assert property (acc |-> hdr_last == (cnt == 5'hf))
      else $error("last flag misplaced");
   done_seq_a: assert property (acc && hdr_last |=> pkt_done && !req_ready ##1 req_ready)
      else $error("done timing wrong");
   ctrl_drop_a: assert property (take && req.is_control |=> pkt_dropped && !hdr_valid)
      else $error("control packet framed");
endmodule
bind tphf_framer tphf_framer_chk #(.SEQ_W(SEQ_W)) tphf_framer_chk_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid), .req(req),
   .req_ready(req_ready), .hdr_valid(hdr_valid), .hdr_byte(hdr_byte), .hdr_last(hdr_last), .hdr_ready(hdr_ready),
   .pkt_done(pkt_done), .pkt_dropped(pkt_dropped));

// File: verification/tphf_sink.sv
// Header sink: stands for the decapsulator taking header bytes.
// Assumes one clock; stall drops ready every other cycle.
`timescale 1ns/1ps
module tphf_sink (
   input  logic         clk,
   input  logic         rst,
   input  logic         stall,
   input  logic         hdr_valid,
   input  logic [7:0]   hdr_byte,
   output logic         hdr_ready,
   output logic [127:0] got
);
   // Toggling ready forces the framer to hold each byte
   always_ff @(posedge clk) begin
      if (rst) hdr_ready <= 1'b1;
      else hdr_ready <= stall ? ~hdr_ready : 1'b1;
   end
   // Bytes shift in first to last, as on the wire
   always_ff @(posedge clk) begin
      if (hdr_valid && hdr_ready) got <= {got[119:0], hdr_byte};
   end
endmodule

// File: verification/test_tunnel_packet_header_framer.sv
// Bench for the header framer: register port, packer requests, header bytes.
// Assumes tphf_sink on the header side and the bound checker.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; $display("unexpected %0t %h %h", $time, a, b); end end
module test_tunnel_packet_header_framer
   import tphf_pkg::*;
();
   logic        clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, req_valid = 0, stall = 0;
   logic [3:0]  reg_addr = 0;
   logic [31:0] reg_wdata = 0, reg_rdata, xt = 0;
   tphf_req_t   req = '0;
   logic        req_ready, hdr_valid, hdr_last, hdr_ready, pkt_done, pkt_dropped;
   logic [7:0]  hdr_byte;
   logic [127:0] got;
   logic [6:0]  pt = 7'h51;
   logic [1:0]  ch = 0;
   logic [15:0] sq = 0;
   int          mismatches = 0, n_tests = 0;
   always #2.5 clk = ~clk;
   tphf_framer tphf_framer_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .hdr_valid(hdr_valid), .hdr_byte(hdr_byte), .hdr_last(hdr_last), .hdr_ready(hdr_ready),
      .pkt_done(pkt_done), .pkt_dropped(pkt_dropped));
   tphf_sink tphf_sink_inst (.clk(clk), .rst(rst), .stall(stall), .hdr_valid(hdr_valid), .hdr_byte(hdr_byte),
      .hdr_ready(hdr_ready), .got(got));
   ////////////////////////////////////////
   // Register port cycles; read data is looked at in the one cycle it stands
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 `CHK(reg_rdata, e)
   endtask
   // One frame; expected header built from the field layout and bench state
   task automatic send(input tphf_req_t r);
      logic [31:0]  t;
      logic [127:0] e;
      t = (pt == 7'h51 || pt == 7'h52) ? (r.info_present ? r.earliest_time : 32'h0) : (pt == 7'h61 ? xt : 32'h0);
      e = {2'h2, r.padding, r.extension, 4'h0, r.start_present, pt, sq, t, 2'h1,
           (pt == 7'h61) ? {2'h0, ch, 10'h0} : 14'h0, r.start_present ? r.start_offset : 16'h0, 32'h0};
      @(posedge clk);
      req       <= r;
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      for (int i = 0; i < 200 && pkt_done !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      `CHK(got, e)
      sq = sq + 16'h1;
      repeat (2) @(posedge clk);
   endtask
   ////////////////////////////////////////
   task automatic t_reset;
      rd(TPHF_REG_SEQ, 32'h0);
      rd(TPHF_REG_CTRL, 32'h51);
      rd(4'hf, 32'h0);
   endtask
   // Sequence wrap under a stalling sink, marker set then clear
   task automatic t_data;
      wr(TPHF_REG_SEQ, 32'hffff);
      sq = 16'hffff;
      stall <= 1'b1;
      send({1'b1, 16'h1234, 1'b1, 32'habcd5678, 1'b1, 1'b0, 16'h0, 1'b0});
      send({1'b0, 16'h0055, 1'b0, 32'h13572468, 1'b0, 1'b0, 16'h0, 1'b0});
      stall <= 1'b0;
      rd(TPHF_REG_SEQ, 32'h1);
      wr(TPHF_REG_CTRL, 32'h52);
      pt = 7'h52;
      send({1'b1, 16'h0, 1'b1, 32'h00010002, 1'b0, 1'b0, 16'h0, 1'b0});
   endtask
   // Transmitter link with two channels, then one channel best effort
   task automatic t_xmit;
      wr(TPHF_REG_CTRL, 32'h161);
      wr(TPHF_REG_XLINK_TIME, 32'h89abcdef);
      pt = 7'h61;
      ch = 2'h1;
      xt = 32'h89abcdef;
      send({1'b1, 16'h0010, 1'b1, 32'h11111111, 1'b0, 1'b0, 16'h0, 1'b0});
      rd(TPHF_REG_XLINK_TIME, 32'h89abcdef);
      wr(TPHF_REG_CTRL, 32'h61);
      wr(TPHF_REG_XLINK_TIME, 32'h0);
      ch = 2'h0;
      xt = 32'h0;
      send({1'b0, 16'h0, 1'b0, 32'h0, 1'b1, 1'b0, 16'h0, 1'b0});
      wr(TPHF_REG_CTRL, 32'h10);
      pt = 7'h10;
      send({1'b1, 16'h0003, 1'b1, 32'h22222222, 1'b0, 1'b0, 16'h0, 1'b0});
   endtask
   // Control request is dropped, then extension length must stay fixed
   task automatic t_ctrl_ext;
      @(posedge clk);
      req       <= {68'h0, 1'b1};
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      #1 `CHK({pkt_dropped, hdr_valid}, 2'b10)
      rd(TPHF_REG_STATUS, 32'h2);
      wr(TPHF_REG_STATUS, 32'h2);
      rd(TPHF_REG_STATUS, 32'h0);
      send({1'b1, 16'h0, 1'b0, 32'h0, 1'b0, 1'b1, 16'h3, 1'b0});
      send({1'b1, 16'h0, 1'b0, 32'h0, 1'b0, 1'b1, 16'h5, 1'b0});
      rd(TPHF_REG_STATUS, 32'h5);
      rd(TPHF_REG_EXT_LEN, 32'h3);
      rd(TPHF_REG_COUNT, 32'h8);
   endtask
   task automatic test_done;
      if (mismatches == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_data;
      t_xmit;
      t_ctrl_ext;
      test_done;
   end
   // The run needs well under 1000 cycles; a hang ends here
   initial begin
      #20000;
      mismatches++;
      test_done;
   end
endmodule
